// ### bench/sru_bench.sv
/*
  Bench: CPU end and device joined by sru_if, plus a second device driven
  directly so key rules can be broken on purpose.
  Assumes sru_cfg.svh is on the include path.
*/
`timescale 1ns/1ps
`include "sru_cfg.svh"
module sru_bench;
  import sru_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_vld = 1'b0;
  sru_op_t cmd_op = OP_READ;
  sru_sel_t cmd_sel = SEL_SYSCFG;
  logic [15:0] cmd_data = 16'h0000;
  logic [15:0] cmd_mask = 16'h0000;
  sru_iclass_t cmd_class = IC_MOVE;
  logic cmd_rdy, rsp_vld, locked, unlock_open, clk_basic, pll_on, pll_off;
  logic [15:0] rsp_data, rd, sys_cfg, sleep_cfg, clkrel_cfg, periph_cfg, rst_cfg, sleep_b, clkrel_b;
  int failures = 0;
  int total_checks = 0;
  sru_if bus ();
  sru_if bus_b ();

  always #5 clk_sys = ~clk_sys;

  sru_cpu i_sru_cpu (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus(bus.cpu), .cmd_vld(cmd_vld),
    .cmd_op(cmd_op), .cmd_sel(cmd_sel), .cmd_data(cmd_data), .cmd_mask(cmd_mask),
    .cmd_class(cmd_class), .cmd_rdy(cmd_rdy), .rsp_vld(rsp_vld), .rsp_data(rsp_data));
  sru_device i_sru_device (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus(bus.dev), .locked(locked),
    .unlock_open(unlock_open), .sys_cfg(sys_cfg), .sleep_cfg(sleep_cfg), .clkrel_cfg(clkrel_cfg),
    .periph_cfg(periph_cfg), .rst_cfg(rst_cfg), .clk_basic(clk_basic),
    .clk_sdd_pll_on(pll_on), .clk_sdd_pll_off(pll_off));
  sru_device i_sru_device_b (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus(bus_b.dev), .locked(),
    .unlock_open(), .sys_cfg(), .sleep_cfg(sleep_b), .clkrel_cfg(clkrel_b), .periph_cfg(),
    .rst_cfg(), .clk_basic(), .clk_sdd_pll_on(), .clk_sdd_pll_off());
  sru_monitor i_sru_monitor (.clk_sys(clk_sys), .sys_rst(sys_rst), .wr_vld(bus.wr_vld),
    .rd_vld(bus.rd_vld), .sel(bus.sel), .wdata(bus.wdata), .wmask(bus.wmask),
    .iclass(bus.iclass), .ext_lock(bus.ext_lock), .end_of_init_instr(bus.end_of_init_instr), .rdata(bus.rdata),
    .rack(bus.rack), .blk(bus.blk));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp);
    chk({15'h0, got}, {15'h0, exp});
  endtask

  task automatic conclude();
    if (failures == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic cmd(input sru_op_t op, input sru_sel_t s, input logic [15:0] d,
    input logic [15:0] m, input sru_iclass_t c);
    int n;
    n = 0;
    while (cmd_rdy !== 1'b1 && n < 50)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    cmd_vld = 1'b1;
    cmd_op = op;
    cmd_sel = s;
    cmd_data = d;
    cmd_mask = m;
    cmd_class = c;
    @(posedge clk_sys);
    #1;
    cmd_vld = 1'b0;
    while ((op == OP_READ || op == OP_SECURE) && rsp_vld !== 1'b1 && n < 50)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    rd = rsp_data;
    if (n >= 50)
      failures++;
    // let the write land and the clock decode follow
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  task automatic bwr(input sru_sel_t s, input logic [15:0] d, input logic [15:0] m,
    input sru_iclass_t c, input logic lk);
    @(posedge clk_sys);
    #1;
    bus_b.wr_vld = 1'b1;
    bus_b.sel = s;
    bus_b.wdata = d;
    bus_b.wmask = m;
    bus_b.iclass = c;
    bus_b.ext_lock = lk;
  endtask

  task automatic t_init();
    chk(sleep_cfg, `SRU_RST_VAL);
    chkb(clk_basic, 1'b1);
    cmd(OP_WRITE, SEL_SLEEP, 16'h1234, 16'hFFFF, IC_MOVE);
    chk(sleep_cfg, 16'h1234);
    cmd(OP_END_OF_INIT_INSTR, SEL_SYSCFG, 16'h0000, 16'h0000, IC_MOVE);
    chkb(locked, 1'b1);
  endtask

  task automatic t_locked();
    cmd(OP_WRITE, SEL_SLEEP, 16'hFFFF, 16'hFFFF, IC_RMW);
    chk(sleep_cfg, 16'h1234);
    cmd(OP_WRITE, SEL_SYSCFG, 16'hFFFF, 16'hFFFF, IC_MOVE);
    chk(sys_cfg, 16'h0000);
    cmd(OP_WRITE, SEL_CLKREL, 16'h0305, 16'hFFFF, IC_MOVE);
    chk(clkrel_cfg, 16'h0005);
    cmd(OP_READ, SEL_SLEEP, 16'h0000, 16'h0000, IC_MOVE);
    chk(rd, 16'h1234);
    cmd(OP_WRITE, sru_sel_t'(3'h6), 16'hFFFF, 16'hFFFF, IC_MOVE);
    cmd(OP_READ, sru_sel_t'(3'h5), 16'h0000, 16'h0000, IC_MOVE);
    chk(rd, 16'h0000);
  endtask

  task automatic t_secure();
    logic [1:0] code [3];
    code = '{`SRU_CLK_SDD_PLL_ON, `SRU_CLK_SDD_PLL_OFF, `SRU_CLK_BASIC};
    for (int i = 0; i < 3; i++)
    begin
      cmd(OP_SECURE, SEL_CLKREL, {6'h00, code[i], 8'h00}, 16'h0300, IC_MOVE);
      chk(clkrel_cfg, {6'h00, code[i], 8'h00});
      chkb(pll_on, code[i] == `SRU_CLK_SDD_PLL_ON);
      chkb(pll_off, code[i] == `SRU_CLK_SDD_PLL_OFF);
      chkb(clk_basic, code[i] == `SRU_CLK_BASIC);
      chkb(unlock_open, 1'b0);
    end
    cmd(OP_SECURE, SEL_PERIPH, 16'hBEEF, 16'hFFFF, IC_MOVE);
    chk(periph_cfg, 16'hBEEF);
    cmd(OP_SECURE, SEL_RSTCFG, 16'h00C3, 16'hFFFF, IC_MOVE);
    chk(rst_cfg, 16'h00C3);
    cmd(OP_SECURE, SEL_SYSCFG, 16'h5555, 16'hFFFF, IC_MOVE);
    chk(sys_cfg, 16'h0000);
    cmd(OP_WRITE, SEL_PERIPH, 16'h0000, 16'hFFFF, IC_MOVE);
    chk(periph_cfg, 16'hBEEF);
  endtask

  // only the first pass is a clean sequence; the rest break one step each
  task automatic t_abort();
    sru_iclass_t c1 [4];
    sru_iclass_t c3 [4];
    logic lk2 [4];
    c1 = '{IC_RMW, IC_MOVE, IC_RMW, IC_RMW};
    c3 = '{IC_BIT, IC_BIT, IC_BIT, IC_MOVE};
    lk2 = '{1'b1, 1'b1, 1'b0, 1'b1};
    @(posedge clk_sys);
    #1;
    bus_b.end_of_init_instr = 1'b1;
    @(posedge clk_sys);
    #1;
    bus_b.end_of_init_instr = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      bwr(SEL_CLKREL, 16'h0000, 16'h000F, IC_MOVE, 1'b0);
      bwr(SEL_CLKREL, 16'h0009, 16'h000F, c1[i], 1'b1);
      bwr(SEL_CLKREL, 16'h0003, 16'hFFFF, IC_MOVE, lk2[i]);
      bwr(SEL_CLKREL, 16'h0004, 16'h0004, c3[i], 1'b1);
      bwr(SEL_SLEEP, 16'h00A0 + 16'(i), 16'hFFFF, IC_MOVE, 1'b1);
      @(posedge clk_sys);
      #1;
      bus_b.wr_vld = 1'b0;
      bus_b.ext_lock = 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      chk(sleep_b, 16'h00A0);
      chk({12'h000, clkrel_b[3:0]}, (i == 0) ? 16'h0000 : 16'h0007);
    end
  endtask

  initial
  begin
    bus_b.wr_vld = 1'b0;
    bus_b.rd_vld = 1'b0;
    bus_b.end_of_init_instr = 1'b0;
    bus_b.ext_lock = 1'b0;
    bus_b.sel = SEL_SYSCFG;
    bus_b.wdata = 16'h0000;
    bus_b.wmask = 16'h0000;
    bus_b.iclass = IC_MOVE;
    repeat (12) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    t_init();
    t_locked();
    t_secure();
    t_abort();
    conclude();
  end

  // tests need well under 1000 cycles; this is ten times that
  initial
  begin
    #100000;
    failures++;
    conclude();
  end
endmodule

// ### bench/sru_monitor.sv
/*
  Checker for the link between the CPU end and the secured register bank.
  Assumes it sits beside the sru_if instance and sees its signals as plain inputs.
*/
`timescale 1ns/1ps
`include "sru_cfg.svh"
module sru_monitor (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic wr_vld,
  input wire logic rd_vld,
  input wire sru_pkg::sru_sel_t sel,
  input wire logic [15:0] wdata,
  input wire logic [15:0] wmask,
  input wire sru_pkg::sru_iclass_t iclass,
  input wire logic ext_lock,
  input wire logic end_of_init_instr,
  input wire logic [15:0] rdata,
  input wire logic rack,
  input wire logic blk
);
  import sru_pkg::*;
  logic lk_ff;
  logic nxt_lk;
  // own copy of the lock, so checks need no device internals
  assign nxt_lk = lk_ff | end_of_init_instr;
  always_ff @(posedge clk_sys) lk_ff <= sys_rst ? 1'b0 : nxt_lk;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_clr;
    wr_vld && !ext_lock && iclass == IC_MOVE && wmask[3:0] == 4'hF && wdata[3:0] == 4'h0;
  endsequence
  sequence s_keys;
    ext_lock && wr_vld && iclass == IC_RMW && wdata[3:0] == `SRU_KEY1
    ##1 ext_lock && wr_vld && iclass == IC_MOVE && wdata[3:0] == `SRU_KEY2
    ##1 ext_lock && wr_vld && iclass == IC_BIT && wdata[`SRU_KEY3_BIT];
  endsequence

  property p_rack; rd_vld |=> rack; endproperty
  property p_rack_one; !rd_vld |=> !rack; endproperty
  property p_unmap; rd_vld && sel > SEL_RSTCFG |=> rack && rdata == 16'h0000; endproperty
  property p_order; $rose(ext_lock) |-> s_keys; endproperty
  property p_clear; $rose(ext_lock) |-> $past(wr_vld && wmask[3:0] == 4'hF && !wdata[0]); endproperty
  property p_win; s_clr ##1 $rose(ext_lock) |-> ext_lock [*4] ##1 !ext_lock; endproperty
  property p_grant;
    lk_ff ##0 s_keys ##1 (wr_vld && ext_lock && sel inside {[SEL_SLEEP:SEL_RSTCFG]}) |=> !blk;
  endproperty
  property p_locked;
    lk_ff && !ext_lock && wr_vld && sel inside {SEL_SLEEP, SEL_PERIPH, SEL_RSTCFG} |=> blk;
  endproperty
  property p_sys; lk_ff && wr_vld && sel == SEL_SYSCFG |=> blk; endproperty
  property p_rel; lk_ff && wr_vld && sel == SEL_CLKREL |=> !blk; endproperty

  a_rack: assert property (p_rack) else $error("read not answered");
  a_rack_one: assert property (p_rack_one) else $error("stray read answer");
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  a_order: assert property (p_order) else $error("key steps wrong");
  a_clear: assert property (p_clear) else $error("no clear before keys");
  a_win: assert property (p_win) else $error("locked window not four long");
  a_grant: assert property (p_grant) else $error("granted write refused");
  a_locked: assert property (p_locked) else $error("locked write taken");
  a_sys: assert property (p_sys) else $error("main config write taken");
  a_rel: assert property (p_rel) else $error("release field write refused");
endmodule

// ### logic/sru_cfg.svh
/*
  Constants of the secured register unlock block: key values, field
  positions, reset values and clock select codes.
  Assumes inclusion by bare name from every design file that needs them.
*/
`ifndef SRU_CFG_SVH
`define SRU_CFG_SVH

// release key field, low nibble of the clock and release register
`define SRU_REL_LSB 0
`define SRU_REL_MSB 3
`define SRU_KEY_CLEAR 4'h0
`define SRU_KEY1 4'h9
`define SRU_KEY2 4'h3
`define SRU_KEY3 4'h7
`define SRU_KEY3_BIT 2

// clock select field inside the clock and release register
`define SRU_CLKSEL_LSB 8
`define SRU_CLKSEL_MSB 9
`define SRU_CLK_BASIC 2'h0
`define SRU_CLK_SDD_PLL_ON 2'h1
`define SRU_CLK_SDD_PLL_OFF 2'h2

`define SRU_RST_VAL 16'h0000
`define SRU_NREG 5
`define SRU_WIN_LEN 4

`endif

// ### logic/sru_cpu.sv
/*
  CPU end: turns user commands into register accesses and runs the
  clear, three keys and target write for a secured write.
  Assumes the device answers a read in the next cycle with rack.
*/
`timescale 1ns/1ps
module sru_cpu (
  input wire logic clk_sys,
  input wire logic sys_rst,
  sru_if.cpu bus,
  input wire logic cmd_vld,
  input wire sru_pkg::sru_op_t cmd_op,
  input wire sru_pkg::sru_sel_t cmd_sel,
  input wire logic [15:0] cmd_data,
  input wire logic [15:0] cmd_mask,
  input wire sru_pkg::sru_iclass_t cmd_class,
  output logic cmd_rdy,
  output logic rsp_vld,
  output logic [15:0] rsp_data
);
  import sru_pkg::*;
  `include "sru_cfg.svh"

  sru_cst_t st_ff, nxt_st;
  logic wr_ff, rd_ff, ei_ff, lock_ff, rdy_ff, rsp_vld_ff;
  logic nxt_wr, nxt_rd, nxt_ei, nxt_lock, nxt_rsp_vld;
  sru_sel_t sel_ff, nxt_sel, h_sel_ff;
  sru_iclass_t cls_ff, nxt_cls, h_cls_ff;
  logic [15:0] wd_ff, wm_ff, nxt_wd, nxt_wm, h_data_ff, h_mask_ff, rsp_ff, nxt_rsp;

  wire logic take = cmd_vld && rdy_ff && st_ff == CS_IDLE;
  wire logic [15:0] key_bit = 16'h0001 << `SRU_KEY3_BIT;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_wr = 1'b0;
    nxt_rd = 1'b0;
    nxt_ei = 1'b0;
    nxt_lock = 1'b0;
    nxt_sel = sel_ff;
    nxt_wd = 16'h0000;
    nxt_wm = 16'h0000;
    nxt_cls = IC_MOVE;
    nxt_rsp_vld = 1'b0;
    nxt_rsp = rsp_ff;
    case (st_ff)
      CS_IDLE:
      begin
        if (take)
        begin
          nxt_sel = cmd_sel;
          case (cmd_op)
            OP_READ:
            begin
              nxt_st = CS_RDW;
              nxt_rd = 1'b1;
            end
            OP_WRITE:
            begin
              nxt_wr = 1'b1;
              nxt_wd = cmd_data;
              nxt_wm = cmd_mask;
              nxt_cls = cmd_class;
            end
            OP_END_OF_INIT_INSTR:
              nxt_ei = 1'b1;
            OP_SECURE:
            begin
              // field cleared first so an OR-type first key lands exactly
              nxt_st = CS_CLR;
              nxt_wr = 1'b1;
              nxt_sel = SEL_CLKREL;
              nxt_wm = 16'h000F;
            end
            default:
              nxt_st = CS_IDLE;
          endcase
        end
      end
      CS_CLR:
      begin
        nxt_st = CS_K1;
        nxt_wr = 1'b1;
        nxt_lock = 1'b1;
        nxt_sel = SEL_CLKREL;
        nxt_wd = {12'h000, `SRU_KEY1};
        nxt_wm = 16'h000F;
        nxt_cls = IC_RMW;
      end
      CS_K1:
      begin
        nxt_st = CS_K2;
        nxt_wr = 1'b1;
        nxt_lock = 1'b1;
        nxt_sel = SEL_CLKREL;
        nxt_wd = {12'h000, `SRU_KEY2};
        nxt_wm = 16'hFFFF;
        nxt_cls = IC_MOVE;
      end
      CS_K2:
      begin
        nxt_st = CS_K3;
        nxt_wr = 1'b1;
        nxt_lock = 1'b1;
        nxt_sel = SEL_CLKREL;
        nxt_wd = key_bit;
        nxt_wm = key_bit;
        nxt_cls = IC_BIT;
      end
      CS_K3:
      begin
        nxt_st = CS_TGT;
        nxt_wr = 1'b1;
        nxt_lock = 1'b1;
        nxt_sel = h_sel_ff;
        nxt_wd = h_data_ff;
        nxt_wm = h_mask_ff;
        nxt_cls = h_cls_ff;
      end
      CS_TGT:
      begin
        nxt_st = CS_IDLE;
        nxt_rsp_vld = 1'b1;
        nxt_rsp = 16'h0000;
      end
      CS_RDW:
      begin
        if (bus.rack)
        begin
          nxt_st = CS_IDLE;
          nxt_rsp_vld = 1'b1;
          nxt_rsp = bus.rdata;
        end
      end
      default:
        nxt_st = CS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      st_ff <= CS_IDLE;
      {wr_ff, rd_ff, ei_ff, lock_ff, rdy_ff, rsp_vld_ff} <= 6'h00;
      sel_ff <= SEL_SYSCFG;
      cls_ff <= IC_MOVE;
      {wd_ff, wm_ff, rsp_ff} <= 48'h000000000000;
    end
    else
    begin
      st_ff <= nxt_st;
      {wr_ff, rd_ff, ei_ff, lock_ff} <= {nxt_wr, nxt_rd, nxt_ei, nxt_lock};
      rdy_ff <= nxt_st == CS_IDLE;
      rsp_vld_ff <= nxt_rsp_vld;
      sel_ff <= nxt_sel;
      cls_ff <= nxt_cls;
      {wd_ff, wm_ff, rsp_ff} <= {nxt_wd, nxt_wm, nxt_rsp};
    end
  end

  // target of a secured write, held while the keys go out
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      h_sel_ff <= SEL_SYSCFG;
      h_cls_ff <= IC_MOVE;
      {h_data_ff, h_mask_ff} <= 32'h00000000;
    end
    else if (take)
    begin
      h_sel_ff <= cmd_sel;
      h_cls_ff <= cmd_class;
      {h_data_ff, h_mask_ff} <= {cmd_data, cmd_mask};
    end
  end

  assign bus.wr_vld = wr_ff;
  assign bus.rd_vld = rd_ff;
  assign bus.end_of_init_instr = ei_ff;
  assign bus.ext_lock = lock_ff;
  assign bus.sel = sel_ff;
  assign bus.wdata = wd_ff;
  assign bus.wmask = wm_ff;
  assign bus.iclass = cls_ff;
  assign cmd_rdy = rdy_ff;
  assign rsp_vld = rsp_vld_ff;
  assign rsp_data = rsp_ff;
endmodule

// ### logic/sru_device.sv
/*
  Secured system control register bank with write lock after the
  end-of-initialisation instruction and a three-step unlock sequence.
  Assumes the CPU end on sru_if presents at most one access per cycle
  and holds ext_lock high across its interrupt-locked window.
*/
`timescale 1ns/1ps
// Operation
// - after init only release field stays writable
// - reads always allowed, locked or not
// - step one: 1001B by read-modify-write
// - step two: 0011B by plain move
// - step three: 0111B by bit instruction
// - good sequence grants one write, then relock
// - keys and write inside four-instruction locked window
// - abort when locked window misses a step
// - main configuration register never unlocked
// - success clears field, failure keeps last value
// - clear field before an OR-type first step
// - exactly five registers are protected; the bank locks all five after init
// - clearing field bits outside window always accepted
// - clock select 01B slowdown PLL on, 00B basic
// - clock select 10B slowdown, PLL off
module sru_device (
  input wire logic clk_sys,
  input wire logic sys_rst,
  sru_if.dev bus,
  output logic locked,
  output logic unlock_open,
  output logic [15:0] sys_cfg,
  output logic [15:0] sleep_cfg,
  output logic [15:0] clkrel_cfg,
  output logic [15:0] periph_cfg,
  output logic [15:0] rst_cfg,
  output logic clk_basic,
  output logic clk_sdd_pll_on,
  output logic clk_sdd_pll_off
);
  import sru_pkg::*;
  `include "sru_cfg.svh"

  localparam int NREG = `SRU_NREG;

  logic [15:0] regs_ff [0:NREG-1];
  logic locked_ff;
  logic [15:0] rdata_ff;
  logic rack_ff;
  logic blk_ff;
  logic clk_basic_ff;
  logic clk_on_ff;
  logic clk_off_ff;
  logic grant;

  // selection of the addressed register
  wire logic [2:0] idx = bus.sel;
  wire logic sel_ok = idx <= 3'(SEL_RSTCFG);
  wire logic is_sys = bus.sel == SEL_SYSCFG;
  wire logic is_rel = bus.sel == SEL_CLKREL;
  wire logic [15:0] cur = sel_ok ? regs_ff[idx] : 16'h0000;
  wire logic [15:0] merged = sru_merge(cur, bus.wdata, bus.wmask);
  wire logic wr_ok = bus.wr_vld && sel_ok;

  // the main configuration register stays out of reach of the grant
  wire logic full_ok = !locked_ff || (grant && !is_sys && bus.ext_lock);
  wire logic consume = wr_ok && locked_ff && grant && !is_sys && bus.ext_lock;
  wire logic rel_only = wr_ok && is_rel && !full_ok;
  wire logic refused = (wr_ok && !full_ok && !is_rel) || (bus.wr_vld && !sel_ok);

  // value that lands in the addressed register
  wire logic [15:0] wr_val =
    (consume && is_rel) ? {merged[15:4], `SRU_KEY_CLEAR} :
    rel_only ? {cur[15:4], merged[`SRU_REL_MSB:`SRU_REL_LSB]} :
    merged;
  wire logic do_wr = wr_ok && (full_ok || rel_only);

  wire logic [1:0] clk_sel = regs_ff[SEL_CLKREL][`SRU_CLKSEL_MSB:`SRU_CLKSEL_LSB];

  sru_key_seq u_key_seq (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .armed(locked_ff),
    .acc(wr_ok),
    .rel(is_rel),
    .iclass(bus.iclass),
    .key(merged[`SRU_REL_MSB:`SRU_REL_LSB]),
    .ext_lock(bus.ext_lock),
    .grant(grant)
  );

  // lock is one-way until the next system reset
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      locked_ff <= 1'b0;
    else if (bus.end_of_init_instr)
      locked_ff <= 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    for (int i = 0; i < NREG; i++)
    begin
      if (sys_rst)
        regs_ff[i] <= `SRU_RST_VAL;
      else if (do_wr && idx == 3'(i))
        regs_ff[i] <= wr_val;
      else if (consume && i == int'(SEL_CLKREL))
        regs_ff[i][`SRU_REL_MSB:`SRU_REL_LSB] <= `SRU_KEY_CLEAR;
    end
  end

  // reads never wait on the lock or the key state
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      rdata_ff <= 16'h0000;
      rack_ff <= 1'b0;
    end
    else
    begin
      rack_ff <= bus.rd_vld;
      if (bus.rd_vld)
        rdata_ff <= cur;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      blk_ff <= 1'b0;
    else
      blk_ff <= refused;
  end

  // decoded clock mode, one cycle behind the register
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      clk_basic_ff <= 1'b1;
      clk_on_ff <= 1'b0;
      clk_off_ff <= 1'b0;
    end
    else
    begin
      clk_basic_ff <= clk_sel == `SRU_CLK_BASIC;
      clk_on_ff <= clk_sel == `SRU_CLK_SDD_PLL_ON;
      clk_off_ff <= clk_sel == `SRU_CLK_SDD_PLL_OFF;
    end
  end

  assign bus.rdata = rdata_ff;
  assign bus.rack = rack_ff;
  assign bus.blk = blk_ff;
  assign locked = locked_ff;
  // grant is decoded from the key tracker's state flop
  assign unlock_open = grant;
  assign sys_cfg = regs_ff[SEL_SYSCFG];
  assign sleep_cfg = regs_ff[SEL_SLEEP];
  assign clkrel_cfg = regs_ff[SEL_CLKREL];
  assign periph_cfg = regs_ff[SEL_PERIPH];
  assign rst_cfg = regs_ff[SEL_RSTCFG];
  assign clk_basic = clk_basic_ff;
  assign clk_sdd_pll_on = clk_on_ff;
  assign clk_sdd_pll_off = clk_off_ff;
endmodule

// ### logic/sru_if.sv
/*
  Link between the CPU end and the secured register bank.
  Assumes both ends run on the same clk_sys; one access per cycle.
*/
`timescale 1ns/1ps
interface sru_if;
  import sru_pkg::*;
  logic wr_vld;
  logic rd_vld;
  sru_sel_t sel;
  logic [15:0] wdata;
  logic [15:0] wmask;
  sru_iclass_t iclass;
  logic ext_lock;
  logic end_of_init_instr;
  logic [15:0] rdata;
  logic rack;
  logic blk;

  modport dev (
    input wr_vld, rd_vld, sel, wdata, wmask, iclass, ext_lock, end_of_init_instr,
    output rdata, rack, blk
  );
  modport cpu (
    output wr_vld, rd_vld, sel, wdata, wmask, iclass, ext_lock, end_of_init_instr,
    input rdata, rack, blk
  );
endinterface

// ### logic/sru_key_seq.sv
/*
  Three-step key tracker; raises grant for one secured write.
  Assumes acc is a one-cycle write strobe and key is the release nibble
  that the write would leave behind.
*/
`timescale 1ns/1ps
module sru_key_seq (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic armed,
  input wire logic acc,
  input wire logic rel,
  input wire sru_pkg::sru_iclass_t iclass,
  input wire logic [3:0] key,
  input wire logic ext_lock,
  output logic grant
);
  import sru_pkg::*;
  `include "sru_cfg.svh"

  sru_kst_t st_ff;
  sru_kst_t nxt_st;

  wire logic step1 = acc && rel && iclass == IC_RMW && key == `SRU_KEY1;
  wire logic step2 = acc && rel && iclass == IC_MOVE && key == `SRU_KEY2;
  wire logic step3 = acc && rel && iclass == IC_BIT && key == `SRU_KEY3;

  always_comb
  begin
    nxt_st = st_ff;
    case (st_ff)
      KS_IDLE:
      begin
        if (armed && ext_lock && step1)
          nxt_st = KS_K1;
      end
      KS_K1:
      begin
        // leaving the locked window or any other write to a mapped register cancels
        if (!ext_lock)
          nxt_st = KS_IDLE;
        else if (acc)
          nxt_st = step2 ? KS_K2 : KS_IDLE;
      end
      KS_K2:
      begin
        if (!ext_lock)
          nxt_st = KS_IDLE;
        else if (acc)
          nxt_st = step3 ? KS_GRANT : KS_IDLE;
      end
      KS_GRANT:
      begin
        // any single write to a mapped register uses the grant up, good or refused
        if (!ext_lock || acc)
          nxt_st = KS_IDLE;
      end
      default:
        nxt_st = KS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      st_ff <= KS_IDLE;
    else
      st_ff <= nxt_st;
  end

  assign grant = st_ff == KS_GRANT;
endmodule

// ### logic/sru_pkg.sv
/*
  Types shared by both ends of the secured register unlock block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sru_pkg;

  typedef enum logic [2:0] {
    SEL_SYSCFG = 3'h0,
    SEL_SLEEP = 3'h1,
    SEL_CLKREL = 3'h2,
    SEL_PERIPH = 3'h3,
    SEL_RSTCFG = 3'h4
  } sru_sel_t;

  typedef enum logic [1:0] {
    IC_MOVE = 2'h0,
    IC_RMW = 2'h1,
    IC_BIT = 2'h2
  } sru_iclass_t;

  typedef enum logic [1:0] {
    OP_READ = 2'h0,
    OP_WRITE = 2'h1,
    OP_END_OF_INIT_INSTR = 2'h2,
    OP_SECURE = 2'h3
  } sru_op_t;

  typedef enum logic [3:0] {
    KS_IDLE = 4'h1,
    KS_K1 = 4'h2,
    KS_K2 = 4'h4,
    KS_GRANT = 4'h8
  } sru_kst_t;

  typedef enum logic [6:0] {
    CS_IDLE = 7'h01,
    CS_RDW = 7'h02,
    CS_CLR = 7'h04,
    CS_K1 = 7'h08,
    CS_K2 = 7'h10,
    CS_K3 = 7'h20,
    CS_TGT = 7'h40
  } sru_cst_t;

  // bits under the mask take the new data, the rest keep the old value
  function automatic logic [15:0] sru_merge(
    input logic [15:0] old_v,
    input logic [15:0] new_v,
    input logic [15:0] mask
  );
    sru_merge = (old_v & ~mask) | (new_v & mask);
  endfunction

endpackage
